/* hw/rfic_irq_ctrl.sv */
// Notes on behaviour
// - two 8-bit flag registers, each paired with an 8-bit enable register
// - bit 7 of a flag or enable write selects set or clear for bits 0 to 6
// - software configures sources, forces requests and clears pending ones
// - enabled event sets status pending bit; pin follows only when pin enabled
// - timer 0..3 underflow sets its secondary timer flag
// - transmitter data-to-end-of-frame step sets transmit-complete flag
// - end of received stream sets receive-complete flag
// - command completing to idle sets command-finished flag
// - one watermark gives high threshold from top, low from bottom
// - high status rising sets high warning flag; extension bit widens watermark
// - low status rising sets low warning flag
// - any receive error bit set sets the error flag
// - card detected in low-power detection mode sets card-detect flag
// - start-of-frame or subcarrier detected sets start-of-frame flag
// - global flag set while any enabled source flag is set
//
// Decided for this implementation: the register offsets and register access over Wishbone.
module rfic_irq_ctrl #(
   parameter int FIFO_DEPTH = rfic_pkg::RFIC_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire rfic_pkg::rfic_events_t events_i,
   output logic irq_o
);
   import rfic_pkg::*;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] flags_pri_reg;
   logic [7:0] flags_sec_reg;
   logic [7:0] en_pri_reg;
   logic [7:0] en_sec_reg;
   logic [7:0] ctrl_reg;
   logic [8:0] wm_reg;
   logic [2:0] sticky_reg;
   logic hi_status_reg;
   logic lo_status_reg;
   logic cmd_running_reg;
   logic [3:0] rst_seen_reg;
   rfic_bus_state_t bus_state_reg;

   logic [7:0] flags_pri_next;
   logic [7:0] flags_sec_next;
   logic [7:0] hw_pri;
   logic [7:0] hw_sec;
   logic hi_status_next;
   logic lo_status_next;
   logic wr_strobe;
   logic bus_take;
   logic [7:0] wbyte;
   logic [6:0] src_pending;

   // writes land at the edge that samples ack high
   assign wr_strobe = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && (bus_state_reg == RFIC_BUS_ACK);
   assign bus_take = wb_cyc_i && wb_stb_i && (bus_state_reg == RFIC_BUS_IDLE);
   assign wbyte = wb_dat_i[7:0];

   // ---------------------------------------------------------------
   // fifo thresholds
   // ---------------------------------------------------------------
   always_comb begin
      // high threshold counted from the top, low from the bottom
      hi_status_next = ({1'b0, events_i.fifo_count} >= (11'(FIFO_DEPTH) - {2'b00, wm_reg}));
      lo_status_next = ({1'b0, events_i.fifo_count} <= {2'b00, wm_reg});
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hi_status_reg <= 1'b0;
         lo_status_reg <= 1'b0;
         cmd_running_reg <= 1'b0;
      end else begin
         hi_status_reg <= hi_status_next;
         lo_status_reg <= lo_status_next;
         cmd_running_reg <= events_i.cmd_running;
      end
   end

   a_lo_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(lo_status_reg) |-> flags_pri_reg[RFIC_P_LO])
      else $error("low warning flag missing");

   // ---------------------------------------------------------------
   // hardware set terms
   // ---------------------------------------------------------------
   always_comb begin
      hw_pri = 8'h00;
      hw_pri[RFIC_P_TX] = events_i.tx_data_to_eof;
      hw_pri[RFIC_P_RX] = events_i.rx_end;
      hw_pri[RFIC_P_IDLE] = cmd_running_reg && events_i.cmd_idle;
      hw_pri[RFIC_P_HI] = hi_status_next && !hi_status_reg;
      hw_pri[RFIC_P_LO] = lo_status_next && !lo_status_reg;
      hw_pri[RFIC_P_ERR] = |events_i.rx_error;
      hw_pri[RFIC_P_SOF] = events_i.sof_detect;
      hw_sec = 8'h00;
      hw_sec[RFIC_S_TMR0 +: 4] = events_i.timer_underflow;
      hw_sec[RFIC_S_CARD] = events_i.card_detect && events_i.low_power_card_detection_mode;
   end

   a_timer_all: assert property (@(posedge clk_i) disable iff (rst_i)
      (events_i.timer_underflow != 4'h0) |=>
      ((flags_sec_reg[3:0] & $past(events_i.timer_underflow)) == $past(events_i.timer_underflow)))
      else $error("timer flag missing");
   a_card_needs_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      !flags_sec_reg[RFIC_S_CARD] && !(events_i.card_detect && events_i.low_power_card_detection_mode) &&
      !(wr_strobe && wb_adr_i == RFIC_FLAGS_SEC_OFS) |=> !flags_sec_reg[RFIC_S_CARD])
      else $error("card flag set outside detection mode");
   a_idle_needs_run: assert property (@(posedge clk_i) disable iff (rst_i)
      !cmd_running_reg && !flags_pri_reg[RFIC_P_IDLE] &&
      !(wr_strobe && wb_adr_i == RFIC_FLAGS_PRI_OFS) |=> !flags_pri_reg[RFIC_P_IDLE])
      else $error("command finished flag without a running command");

   // ---------------------------------------------------------------
   // set/clear writes; hardware sets win over clears
   // ---------------------------------------------------------------
   function automatic logic [7:0] setclr(input logic [7:0] cur, input logic [7:0] wd);
      logic [7:0] r;
      r = cur;
      if (wd[RFIC_SETCLR_BIT]) begin
         r[6:0] = cur[6:0] | wd[6:0];
      end else begin
         r[6:0] = cur[6:0] & ~wd[6:0];
      end
      r[7] = 1'b0;
      return r;
   endfunction

   always_comb begin
      flags_pri_next = flags_pri_reg;
      flags_sec_next = flags_sec_reg;
      if (wr_strobe && wb_adr_i == RFIC_FLAGS_PRI_OFS) begin
         flags_pri_next = setclr(flags_pri_reg, wbyte);
      end
      if (wr_strobe && wb_adr_i == RFIC_FLAGS_SEC_OFS) begin
         flags_sec_next = setclr(flags_sec_reg, wbyte);
      end
      flags_pri_next = flags_pri_next | hw_pri;
      flags_sec_next[5:0] = flags_sec_next[5:0] | hw_sec[5:0];
      // global flag is derived from the source flags, not written
      flags_sec_next[RFIC_S_GLOBAL] = 1'b0;
      flags_sec_next[7] = 1'b0;
   end

   assign src_pending = {|(flags_pri_reg[6:0] & en_pri_reg[6:0]), flags_sec_reg[5:0] & en_sec_reg[5:0]};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_pri_reg <= RFIC_FLAGS_RST;
         flags_sec_reg <= RFIC_FLAGS_RST;
      end else begin
         flags_pri_reg <= flags_pri_next;
         flags_sec_reg <= flags_sec_next;
         flags_sec_reg[RFIC_S_GLOBAL] <= |src_pending;
      end
   end

   a_global_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      !(|src_pending) |=> !flags_sec_reg[RFIC_S_GLOBAL])
      else $error("global flag without enabled source");
   a_flag_hold_pri: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wr_strobe && wb_adr_i == RFIC_FLAGS_PRI_OFS) |=>
      ((flags_pri_reg & $past(flags_pri_reg)) == $past(flags_pri_reg)))
      else $error("primary flag fell without a clear write");
   a_flag_hold_sec: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wr_strobe && wb_adr_i == RFIC_FLAGS_SEC_OFS) |=>
      ((flags_sec_reg[5:0] & $past(flags_sec_reg[5:0])) == $past(flags_sec_reg[5:0])))
      else $error("secondary flag fell without a clear write");
   a_top_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      !(flags_pri_reg[7] || flags_sec_reg[7] || en_pri_reg[7] || en_sec_reg[7]))
      else $error("selector bit stored");

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_pri_reg <= RFIC_EN_RST;
         en_sec_reg <= RFIC_EN_RST;
      end else if (wr_strobe) begin
         if (wb_adr_i == RFIC_EN_PRI_OFS) begin
            en_pri_reg <= setclr(en_pri_reg, wbyte);
         end
         if (wb_adr_i == RFIC_EN_SEC_OFS) begin
            en_sec_reg <= setclr(en_sec_reg, wbyte);
         end
      end
   end

   a_set_works: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_strobe && wb_adr_i == RFIC_EN_PRI_OFS && wbyte[7] |=>
      ((en_pri_reg[6:0] & $past(wbyte[6:0])) == $past(wbyte[6:0])))
      else $error("enable set failed");
   a_enable_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !wr_strobe |=> (en_pri_reg == $past(en_pri_reg)) && (en_sec_reg == $past(en_sec_reg)))
      else $error("enable changed without a write");

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= RFIC_CTRL_RST;
         wm_reg <= RFIC_WM_RST;
      end else if (wr_strobe) begin
         if (wb_adr_i == RFIC_CTRL_OFS) begin
            ctrl_reg <= wbyte;
         end
         if (wb_adr_i == RFIC_WATERMARK_OFS) begin
            wm_reg[7:0] <= wbyte;
            if (wb_sel_i[1]) begin
               wm_reg[RFIC_WM_EXT] <= wb_dat_i[RFIC_WM_EXT];
            end
         end
      end
   end

   a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_strobe && wb_adr_i == RFIC_CTRL_OFS |=> ctrl_reg == $past(wbyte))
      else $error("control write lost");
   a_wm_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_strobe && wb_adr_i == RFIC_WATERMARK_OFS |=> wm_reg[7:0] == $past(wbyte))
      else $error("watermark write lost");

   // ---------------------------------------------------------------
   // sticky event record: any primary, any secondary, card detect
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sticky_reg <= RFIC_STICKY_RST;
      end else begin
         if (wr_strobe && wb_adr_i == RFIC_STICKY_OFS) begin
            sticky_reg <= sticky_reg & ~wbyte[2:0];
         end
         if (|hw_pri) begin
            sticky_reg[0] <= 1'b1;
         end
         if (|hw_sec) begin
            sticky_reg[1] <= 1'b1;
         end
         if (hw_sec[RFIC_S_CARD]) begin
            sticky_reg[2] <= 1'b1;
         end
      end
   end

   a_sticky_card: assert property (@(posedge clk_i) disable iff (rst_i)
      hw_sec[RFIC_S_CARD] |=> sticky_reg[2])
      else $error("card event not recorded");
   a_sticky_pri: assert property (@(posedge clk_i) disable iff (rst_i)
      (|hw_pri) |=> sticky_reg[0])
      else $error("primary event not recorded");
   a_sticky_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_strobe && wb_adr_i == RFIC_STICKY_OFS && wbyte[0] && !(|hw_pri) |=> !sticky_reg[0])
      else $error("event record not cleared");

   // ---------------------------------------------------------------
   // interrupt pin
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= flags_sec_reg[RFIC_S_GLOBAL] && ctrl_reg[RFIC_CTRL_PINEN];
      end
   end

   a_pin_gated: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctrl_reg[RFIC_CTRL_PINEN] |=> !irq_o)
      else $error("pin active while disabled");
   a_irq_falls: assert property (@(posedge clk_i) disable iff (rst_i)
      !flags_sec_reg[RFIC_S_GLOBAL] |=> !irq_o)
      else $error("pin active without global flag");

   // ---------------------------------------------------------------
   // wishbone slave: ack one cycle after request, then one idle cycle
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_reg <= RFIC_BUS_IDLE;
         wb_ack_o <= 1'b0;
      end else begin
         case (bus_state_reg)
            RFIC_BUS_IDLE: begin
               if (wb_cyc_i && wb_stb_i) begin
                  bus_state_reg <= RFIC_BUS_ACK;
                  wb_ack_o <= 1'b1;
               end
            end
            RFIC_BUS_ACK: begin
               bus_state_reg <= RFIC_BUS_HOLD;
               wb_ack_o <= 1'b0;
            end
            RFIC_BUS_HOLD: begin
               bus_state_reg <= RFIC_BUS_IDLE;
            end
            default: begin
               bus_state_reg <= RFIC_BUS_IDLE;
               wb_ack_o <= 1'b0;
            end
         endcase
      end
   end

   a_ack_gap: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o ##1 !wb_ack_o)
      else $error("ack longer than one cycle or no gap");
   a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_take |=> wb_ack_o)
      else $error("request not acknowledged");
   a_write_in_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_strobe |-> wb_ack_o)
      else $error("write outside ack cycle");
   a_bus_state_legal: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_state_reg != 2'b10)
      else $error("bus state illegal");

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_take) begin
         case (wb_adr_i)
            RFIC_FLAGS_PRI_OFS: wb_dat_o <= {24'h000000, flags_pri_reg};
            RFIC_FLAGS_SEC_OFS: wb_dat_o <= {24'h000000, flags_sec_reg};
            RFIC_EN_PRI_OFS: wb_dat_o <= {24'h000000, en_pri_reg};
            RFIC_EN_SEC_OFS: wb_dat_o <= {24'h000000, en_sec_reg};
            // pending bit shows independent of pin enable
            RFIC_STATUS_OFS: wb_dat_o <= {29'h0, lo_status_reg, hi_status_reg, flags_sec_reg[RFIC_S_GLOBAL]};
            RFIC_CTRL_OFS: wb_dat_o <= {24'h000000, ctrl_reg};
            RFIC_WATERMARK_OFS: wb_dat_o <= {23'h000000, wm_reg};
            RFIC_STICKY_OFS: wb_dat_o <= {29'h0, sticky_reg};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   a_read_stands: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> $stable(wb_dat_o))
      else $error("read data changed after ack");

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_timer_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      events_i.timer_underflow[0] |=> flags_sec_reg[RFIC_S_TMR0])
      else $error("timer underflow did not set flag");
   a_tx_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      events_i.tx_data_to_eof |=> flags_pri_reg[RFIC_P_TX])
      else $error("transmit complete flag missing");
   a_rx_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      events_i.rx_end |=> flags_pri_reg[RFIC_P_RX])
      else $error("receive complete flag missing");
   a_idle_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(events_i.cmd_running) && events_i.cmd_idle |=> flags_pri_reg[RFIC_P_IDLE])
      else $error("command finished flag missing");
   a_err_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (events_i.rx_error != 8'h00) |=> flags_pri_reg[RFIC_P_ERR])
      else $error("error flag missing");
   a_card_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      events_i.card_detect && events_i.low_power_card_detection_mode |=> flags_sec_reg[RFIC_S_CARD])
      else $error("card detect flag missing");
   a_sof_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      events_i.sof_detect |=> flags_pri_reg[RFIC_P_SOF])
      else $error("start of frame flag missing");
   a_global_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (|src_pending) |=> flags_sec_reg[RFIC_S_GLOBAL])
      else $error("global flag not set for enabled source");
   a_irq_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 irq_o == ($past(flags_sec_reg[RFIC_S_GLOBAL]) && $past(ctrl_reg[RFIC_CTRL_PINEN])))
      else $error("interrupt pin mismatch");
   a_clear_works: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_strobe && wb_adr_i == RFIC_EN_PRI_OFS && !wbyte[7] |=> ((en_pri_reg[6:0] & $past(wbyte[6:0])) == 7'h00))
      else $error("enable clear failed");
   a_hi_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(hi_status_reg) |-> flags_pri_reg[RFIC_P_HI])
      else $error("high warning flag missing");
endmodule

/* hw/rfic_pkg.sv */
package rfic_pkg;
   // ---------------------------------------------------------------
   // register word offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [4:0] RFIC_FLAGS_PRI_OFS = 5'h00;
   localparam logic [4:0] RFIC_FLAGS_SEC_OFS = 5'h04;
   localparam logic [4:0] RFIC_EN_PRI_OFS = 5'h08;
   localparam logic [4:0] RFIC_EN_SEC_OFS = 5'h0C;
   localparam logic [4:0] RFIC_STATUS_OFS = 5'h10;
   localparam logic [4:0] RFIC_CTRL_OFS = 5'h14;
   localparam logic [4:0] RFIC_WATERMARK_OFS = 5'h18;
   localparam logic [4:0] RFIC_STICKY_OFS = 5'h1C;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int RFIC_SETCLR_BIT = 7;
   // primary flags
   localparam int RFIC_P_TX = 0;
   localparam int RFIC_P_RX = 1;
   localparam int RFIC_P_IDLE = 2;
   localparam int RFIC_P_HI = 3;
   localparam int RFIC_P_LO = 4;
   localparam int RFIC_P_ERR = 5;
   localparam int RFIC_P_SOF = 6;
   // secondary flags
   localparam int RFIC_S_TMR0 = 0;
   localparam int RFIC_S_CARD = 5;
   localparam int RFIC_S_GLOBAL = 6;
   // status register / control register / watermark register
   localparam int RFIC_STAT_IRQ = 0;
   localparam int RFIC_STAT_HI = 1;
   localparam int RFIC_STAT_LO = 2;
   localparam int RFIC_CTRL_PINEN = 0;
   localparam int RFIC_WM_EXT = 8;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RFIC_FLAGS_RST = 8'h00;
   localparam logic [7:0] RFIC_EN_RST = 8'h00;
   localparam logic [7:0] RFIC_CTRL_RST = 8'h01;
   localparam logic [8:0] RFIC_WM_RST = 9'h008;
   localparam logic [2:0] RFIC_STICKY_RST = 3'h0;

   localparam int RFIC_FIFO_DEPTH = 512;

   typedef struct packed {
      logic [3:0] timer_underflow;
      logic tx_data_to_eof;
      logic rx_end;
      logic cmd_running;
      logic cmd_idle;
      logic [7:0] rx_error;
      logic card_detect;
      logic low_power_card_detection_mode;
      logic sof_detect;
      logic [9:0] fifo_count;
   } rfic_events_t;

   typedef enum logic [1:0] {
      RFIC_BUS_IDLE = 2'b00,
      RFIC_BUS_ACK = 2'b01,
      RFIC_BUS_HOLD = 2'b11
   } rfic_bus_state_t;
endpackage

/* tb/rfic_host_model.sv */
// ---------------------------------------------------------------
// host side: counts interrupt requests seen on the pin
// ---------------------------------------------------------------
module rfic_host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic irq_i,
   output logic [7:0] rises_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic irq_reg;
   // a level request counts once per assertion
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
         rises_o <= 8'h00;
      end else begin
         irq_reg <= irq_i;
         if (irq_i && !irq_reg) begin
            rises_o <= rises_o + 8'h01;
         end
      end
   end
endmodule

/* tb/rfic_irq_ctrl_test.sv */
module rfic_irq_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import rfic_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [4:0] wb_adr = 5'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat_w = 32'h0;
   logic [31:0] wb_dat_r;
   logic wb_ack;
   logic irq;
   logic [7:0] rises;
   rfic_events_t idle = '{fifo_count: 10'h064, default: '0};
   rfic_events_t evt = '{fifo_count: 10'h064, default: '0};
   rfic_events_t e;
   logic [31:0] exp_q[$];
   logic [31:0] seed = 32'd69796;
   int num_errors = 0;
   int total_checks = 0;
   int i;

   always #10 clk_i = ~clk_i;

   rfic_irq_ctrl u_rfic_irq_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
      .wb_ack_o(wb_ack), .events_i(evt), .irq_o(irq));
   rfic_host_model u_rfic_host_model (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .rises_o(rises));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hF;
      wb_dat_w <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack !== 1'b1);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] want);
      exp_q.push_back(want);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic ev(input rfic_events_t e1, input rfic_events_t e2);
      @(posedge clk_i);
      evt <= e1;
      @(posedge clk_i);
      evt <= e2;
      @(posedge clk_i);
      evt <= idle;
      repeat (3) @(posedge clk_i);
   endtask

   task automatic src(input rfic_events_t e1, input rfic_events_t e2, input logic [4:0] a, input logic [7:0] w);
      ev(e1, e2);
      rd(a, {24'h0, w});
      bus(1'b1, a, 32'h7F);
   endtask

   task automatic pin(input logic want);
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      check({31'h0, irq}, {31'h0, want});
   endtask

   // ---------------------------------------------------------------
   // read results are compared as acks appear
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (wb_ack === 1'b1 && exp_q.size() > 0) begin
         check(wb_dat_r, exp_q.pop_front());
      end
   end

   initial begin
      #(20 * 20000);
      num_errors++;
      print_verdict();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(RFIC_EN_PRI_OFS, 32'h00);
      rd(RFIC_EN_SEC_OFS, 32'h00);
      rd(RFIC_CTRL_OFS, 32'h01);
      rd(RFIC_WATERMARK_OFS, 32'h008);
      bus(1'b1, RFIC_FLAGS_PRI_OFS, 32'h7F);
      bus(1'b1, RFIC_EN_PRI_OFS, 32'hFF);
      rd(RFIC_EN_PRI_OFS, 32'h7F);
      bus(1'b1, RFIC_EN_PRI_OFS, 32'h7F);
      bus(1'b1, RFIC_FLAGS_PRI_OFS, 32'h85);
      rd(RFIC_FLAGS_PRI_OFS, 32'h05);
      bus(1'b1, RFIC_FLAGS_PRI_OFS, 32'h04);
      rd(RFIC_FLAGS_PRI_OFS, 32'h01);
      bus(1'b1, RFIC_FLAGS_PRI_OFS, 32'h80);
      rd(RFIC_FLAGS_PRI_OFS, 32'h01);
      bus(1'b1, RFIC_FLAGS_PRI_OFS, 32'h01);
      pin(1'b0);
      // software forced request reaches the pin only when enabled
      bus(1'b1, RFIC_EN_PRI_OFS, 32'h81);
      bus(1'b1, RFIC_FLAGS_PRI_OFS, 32'h81);
      pin(1'b1);
      check({24'h0, rises}, 32'h01);
      rd(RFIC_STATUS_OFS, 32'h01);
      rd(RFIC_FLAGS_SEC_OFS, 32'h40);
      bus(1'b1, RFIC_CTRL_OFS, 32'h00);
      pin(1'b0);
      rd(RFIC_STATUS_OFS, 32'h01);
      bus(1'b1, RFIC_CTRL_OFS, 32'h01);
      bus(1'b1, RFIC_FLAGS_PRI_OFS, 32'h01);
      pin(1'b0);
      rd(RFIC_STATUS_OFS, 32'h00);
      e = idle;
      e.rx_end = 1'b1;
      ev(e, idle);
      pin(1'b0);
      bus(1'b1, RFIC_FLAGS_PRI_OFS, 32'h7F);
      bus(1'b1, RFIC_EN_PRI_OFS, 32'h01);
      rd(RFIC_EN_PRI_OFS, 32'h00);
      // each event source sets its own flag only
      for (i = 0; i < 4; i++) begin
         e = idle;
         e.timer_underflow = 4'h1 << i;
         src(e, idle, RFIC_FLAGS_SEC_OFS, 8'h01 << i);
      end
      e = idle;
      e.tx_data_to_eof = 1'b1;
      src(e, idle, RFIC_FLAGS_PRI_OFS, 8'h01);
      e.tx_data_to_eof = 1'b0;
      e.rx_end = 1'b1;
      src(e, idle, RFIC_FLAGS_PRI_OFS, 8'h02);
      e = idle;
      e.sof_detect = 1'b1;
      src(e, idle, RFIC_FLAGS_PRI_OFS, 8'h40);
      e = idle;
      e.rx_error = 8'(xs() | 32'h01);
      src(e, idle, RFIC_FLAGS_PRI_OFS, 8'h20);
      e = idle;
      e.cmd_running = 1'b1;
      src(e, idle, RFIC_FLAGS_PRI_OFS, 8'h00);
      e.cmd_idle = 1'b1;
      e.cmd_running = 1'b0;
      src(idle, e, RFIC_FLAGS_PRI_OFS, 8'h00);
      e.cmd_running = 1'b1;
      e.cmd_idle = 1'b0;
      e.card_detect = 1'b1;
      src(e, '{cmd_idle: 1'b1, fifo_count: 10'h064, default: '0}, RFIC_FLAGS_PRI_OFS, 8'h04);
      rd(RFIC_FLAGS_SEC_OFS, 32'h00);
      bus(1'b1, RFIC_FLAGS_SEC_OFS, 32'h7F);
      e = idle;
      e.card_detect = 1'b1;
      e.low_power_card_detection_mode = 1'b1;
      src(e, idle, RFIC_FLAGS_SEC_OFS, 8'h20);
      // fifo thresholds from one watermark, top and bottom
      idle.fifo_count = 10'(RFIC_FIFO_DEPTH - 8);
      ev(idle, idle);
      rd(RFIC_STATUS_OFS, 32'h02);
      idle.fifo_count = 10'h008;
      ev(idle, idle);
      rd(RFIC_STATUS_OFS, 32'h04);
      src(idle, idle, RFIC_FLAGS_PRI_OFS, 8'h18);
      idle.fifo_count = 10'h064;
      ev(idle, idle);
      bus(1'b1, RFIC_WATERMARK_OFS, 32'h100);
      idle.fifo_count = 10'(RFIC_FIFO_DEPTH - 256);
      ev(idle, idle);
      rd(RFIC_STATUS_OFS, 32'h06);
      rd(RFIC_STICKY_OFS, 32'h07);
      bus(1'b1, RFIC_STICKY_OFS, 32'h07);
      rd(RFIC_STICKY_OFS, 32'h00);
      print_verdict();
   end
endmodule
